// ---- rtl/uarx_pkg.sv ----
package uarx_pkg;

	// Register byte addresses on the Avalon-MM slave.
	localparam int            ADDR_W        = 8;
	localparam logic [7:0]    ADDR_CTRL     = 8'h00;
	localparam logic [7:0]    ADDR_BAUD     = 8'h04;
	localparam logic [7:0]    ADDR_DATA     = 8'h08;
	localparam logic [7:0]    ADDR_STATUS   = 8'h0C;
	localparam logic [7:0]    ADDR_INT_STAT = 8'h10;
	localparam logic [7:0]    ADDR_INT_MASK = 8'h14;

	// Baud divisor width and reset value.
	localparam int            BAUD_W_DEF    = 12;
	localparam logic [11:0]   BAUD_RESET    = 12'h067;

	// Sampling figures for normal and double-speed modes.
	localparam logic [4:0]    SPB_NORMAL    = 5'h10;
	localparam logic [4:0]    SPB_DOUBLE    = 5'h08;
	localparam logic [4:0]    SF_NORMAL     = 5'h08;
	localparam logic [4:0]    SF_DOUBLE     = 5'h04;

	// Character size code 0..4 selects 5..9 data bits.
	localparam logic [3:0]    CHAR_BASE     = 4'h5;
	localparam logic [3:0]    CHAR_MAX      = 4'h9;
	localparam logic [2:0]    CHAR_SEL_MAX  = 3'h4;
	localparam logic [8:0]    DATA_MASK_ALL = 9'h1FF;

	// Interrupt status and mask bit positions.
	localparam int            INT_W         = 4;
	localparam int            INT_RX        = 0;
	localparam int            INT_FE        = 1;
	localparam int            INT_OVR       = 2;
	localparam int            INT_NOISE     = 3;

	// Status register bit positions.
	localparam int            STAT_RXC      = 0;
	localparam int            STAT_FE       = 1;
	localparam int            STAT_CNT      = 2;
	localparam int            STAT_BUSY     = 4;
	localparam int            STAT_OWNED    = 5;

	// Receive buffer depth is two entries.
	localparam logic [1:0]    FIFO_FULL     = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} uarx_state_e;

	typedef struct packed {
		logic       parity_en;
		logic [2:0] char_sel;
		logic       double_speed;
		logic       enable;
	} uarx_ctrl_s;

	localparam uarx_ctrl_s CTRL_RESET = 6'h0C;

	typedef struct packed {
		logic       frame_err;
		logic [8:0] data;
	} uarx_entry_s;

endpackage

// ---- rtl/uarx_receiver.sv ----
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// - Clearing receiver_enable aborts the frame in progress immediately.
// - While disabled, the receiver releases serial_input_pin to its port.
// - Disabling the receiver flushes the two-entry receive buffer.
// - After a flush by disable, receive_complete_flag reads zero.
// - Sample at sixteen times baud, or eight times in double speed.
// - An idle high-to-low transition starts detection; first low is sample one.
// - Start validated by majority of samples 8,9,10 or 4,5,6.
// - Two or more high validation samples reject start; wait for next edge.
// - Bit timing resynchronises on every validated start bit.
// - Sixteen sample states per bit normally, eight in double speed.
// - Each data and parity bit is the majority of three centre samples.
// - Centre samples start at 8 or 4, middle vote at 9 or 5.
// - Recovery runs through the first stop bit; later stop bits ignored.
// - Stop bit is voted; a zero sets frame_error_flag for that frame.
// - Next falling edge is detected right after the last stop-bit vote.
// - Character plus parity length from five to ten bits is accepted.
module uarx_receiver #(
	parameter int unsigned BAUD_W = uarx_pkg::BAUD_W_DEF
) (
	input  wire logic                         sys_clk_in,
	input  wire logic                         resetn_in,
	input  wire logic [uarx_pkg::ADDR_W-1:0]  avs_address_in,
	input  wire logic                         avs_read_in,
	input  wire logic                         avs_write_in,
	input  wire logic [31:0]                  avs_writedata_in,
	output logic                              avs_waitrequest_out,
	output logic      [31:0]                  avs_readdata_out,
	output logic                              irq_out,
	input  wire logic                         serial_input_pin_in,
	output logic                              serial_input_pin_owned_out
);
	import uarx_pkg::*;

	// Majority of three samples, used for start, data and stop decisions.
	function automatic logic uarx_maj3(input logic a, input logic b,
		input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	// Number of character bits for a size code; codes above four mean nine.
	function automatic logic [3:0] uarx_char_bits(input logic [2:0] sel);
		return (sel > CHAR_SEL_MAX) ? CHAR_MAX : CHAR_BASE + {1'b0, sel};
	endfunction

	logic                  rx_meta;
	logic                  rx_sync;
	uarx_ctrl_s            ctrl;
	uarx_ctrl_s            next_ctrl;
	logic [BAUD_W-1:0]     baud_div;
	logic [BAUD_W-1:0]     next_baud_div;
	logic [BAUD_W-1:0]     baud_cnt;
	logic [BAUD_W-1:0]     next_baud_cnt;
	uarx_state_e           state;
	uarx_state_e           next_state;
	logic [4:0]            samp_cnt;
	logic [4:0]            next_samp_cnt;
	logic [4:0]            cur_num;
	logic [3:0]            bit_idx;
	logic [3:0]            next_bit_idx;
	logic [1:0]            vote;
	logic [1:0]            next_vote;
	logic [9:0]            shreg;
	logic [9:0]            next_shreg;
	logic                  rx_prev;
	logic                  next_rx_prev;
	logic                  tick;
	logic [4:0]            spb;
	logic [4:0]            sf;
	logic [3:0]            char_bits;
	logic [3:0]            frame_len;
	logic                  vote_bit;
	logic                  push;
	logic                  noise_evt;
	uarx_entry_s           push_entry;
	uarx_entry_s           fifo_mem [0:1];
	uarx_entry_s           head;
	logic                  rd_ptr;
	logic                  next_rd_ptr;
	logic [1:0]            fifo_cnt;
	logic [1:0]            next_fifo_cnt;
	logic                  mem_we;
	logic                  mem_idx;
	logic                  pop;
	logic                  push_ok;
	logic                  rx_complete_flag;
	logic [INT_W-1:0]      int_stat;
	logic [INT_W-1:0]      next_int_stat;
	logic [INT_W-1:0]      int_mask;
	logic [INT_W-1:0]      next_int_mask;
	logic [INT_W-1:0]      int_set;
	logic [INT_W-1:0]      int_clr;
	logic                  next_waitreq;
	logic [31:0]           next_readdata;
	logic                  accept;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	// The pin is asynchronous to sys_clk_in, so it passes two flip-flops.
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= serial_input_pin_in;
			rx_sync <= rx_meta;
		end
	end

	// Mode figures and the divider tick that paces every sample.
	assign spb       = ctrl.double_speed ? SPB_DOUBLE : SPB_NORMAL;
	assign sf        = ctrl.double_speed ? SF_DOUBLE : SF_NORMAL;
	assign tick      = ctrl.enable && (baud_cnt == '0);
	assign char_bits = uarx_char_bits(ctrl.char_sel);
	assign frame_len = char_bits + {3'h0, ctrl.parity_en};
	assign cur_num   = (samp_cnt == spb) ? 5'h01 : samp_cnt + 5'h01;
	assign vote_bit  = uarx_maj3(vote[1], vote[0], rx_sync);

	// Clock and data recovery; disable drops any frame in flight at once.
	always_comb begin
		next_state    = state;
		next_samp_cnt = samp_cnt;
		next_bit_idx  = bit_idx;
		next_vote     = vote;
		next_shreg    = shreg;
		next_rx_prev  = rx_prev;
		next_baud_cnt = baud_cnt;
		push          = 1'b0;
		noise_evt     = 1'b0;
		push_entry    = '0;
		if (!ctrl.enable) begin
			next_state    = ST_IDLE;
			next_samp_cnt = 5'h00;
			next_rx_prev  = 1'b1;
			next_baud_cnt = '0;
		end else begin
			next_baud_cnt = tick ? baud_div : baud_cnt - BAUD_W'(1);
			if (tick) begin
				next_rx_prev = rx_sync;
				if (state == ST_IDLE) begin
					// The first low sample after a high one is sample one.
					if (rx_prev && !rx_sync) begin
						next_state    = ST_START;
						next_samp_cnt = 5'h01;
						next_shreg    = '0;
					end
				end else begin
					next_samp_cnt = cur_num;
					if (cur_num == sf)
						next_vote[0] = rx_sync;
					if (cur_num == sf + 5'h01)
						next_vote[1] = rx_sync;
					case (state)
						ST_START: begin
							if (cur_num == sf + 5'h02 && vote_bit) begin
								next_state = ST_IDLE;
								noise_evt  = 1'b1;
							end else if (cur_num == 5'h01) begin
								next_state   = ST_DATA;
								next_bit_idx = 4'h0;
							end
						end
						ST_DATA: begin
							if (cur_num == sf + 5'h02) begin
								next_shreg[bit_idx] = vote_bit;
								next_bit_idx        = bit_idx + 4'h1;
							end else if (cur_num == 5'h01 &&
								bit_idx == frame_len) begin
								next_state = ST_STOP;
							end
						end
						ST_STOP: begin
							// Only the first stop bit is looked at.
							if (cur_num == sf + 5'h02) begin
								push                 = 1'b1;
								push_entry.frame_err = !vote_bit;
								push_entry.data      = shreg[8:0] &
									(DATA_MASK_ALL >> (CHAR_MAX - char_bits));
								next_state           = ST_IDLE;
							end
						end
						default: next_state = ST_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			state    <= ST_IDLE;
			samp_cnt <= 5'h00;
			bit_idx  <= 4'h0;
			vote     <= 2'h0;
			shreg    <= 10'h000;
			rx_prev  <= 1'b1;
			baud_cnt <= '0;
		end else begin
			state    <= next_state;
			samp_cnt <= next_samp_cnt;
			bit_idx  <= next_bit_idx;
			vote     <= next_vote;
			shreg    <= next_shreg;
			rx_prev  <= next_rx_prev;
			baud_cnt <= next_baud_cnt;
		end
	end

	property p_disable_stops;
		!ctrl.enable |=> state == ST_IDLE && !push;
	endproperty
	a_disable_stops: assert property (p_disable_stops)
		else $error("receiver kept running while disabled");

	property p_edge_starts;
		tick && state == ST_IDLE && rx_prev && !rx_sync
			|=> state == ST_START && samp_cnt == 5'h01;
	endproperty
	a_edge_starts: assert property (p_edge_starts)
		else $error("falling edge did not start detection at sample one");

	property p_noise_reject;
		tick && state == ST_START && cur_num == sf + 5'h02 &&
			$countones({vote, rx_sync}) >= 2 |=> state == ST_IDLE;
	endproperty
	a_noise_reject: assert property (p_noise_reject)
		else $error("noisy start bit was not rejected");

	property p_sample_wrap;
		tick && state != ST_IDLE && samp_cnt == spb && ctrl.enable
			|=> samp_cnt == 5'h01;
	endproperty
	a_sample_wrap: assert property (p_sample_wrap)
		else $error("sample counter did not wrap after one bit");

	property p_stop_to_idle;
		tick && state == ST_STOP && cur_num == sf + 5'h02
			|=> state == ST_IDLE;
	endproperty
	a_stop_to_idle: assert property (p_stop_to_idle)
		else $error("receiver not ready for next start after stop vote");

	property p_tick_reload;
		tick |=> baud_cnt == $past(baud_div);
	endproperty
	a_tick_reload: assert property (p_tick_reload)
		else $error("baud divider did not reload on the tick");

	// Two-entry receive buffer; a frame arriving when full is dropped unless a read pops an entry in the same cycle.
	assign head             = fifo_mem[rd_ptr];
	assign rx_complete_flag = (fifo_cnt != 2'h0);
	assign accept           = (avs_read_in || avs_write_in) &&
		!avs_waitrequest_out;
	assign pop     = accept && avs_read_in && avs_address_in == ADDR_DATA &&
		rx_complete_flag;
	assign push_ok = push && (fifo_cnt != FIFO_FULL || pop);
	assign mem_we  = push_ok;
	assign mem_idx = rd_ptr ^ fifo_cnt[0];

	// Register file, buffer pointers and interrupt flags.
	always_comb begin
		next_ctrl     = ctrl;
		next_baud_div = baud_div;
		next_int_mask = int_mask;
		next_rd_ptr   = rd_ptr ^ pop;
		next_fifo_cnt = fifo_cnt + {1'b0, push_ok} - {1'b0, pop};
		int_clr       = '0;
		int_set       = '0;
		next_readdata = avs_readdata_out;
		next_waitreq  = !((avs_read_in || avs_write_in) &&
			avs_waitrequest_out);
		if (accept && avs_write_in) begin
			if (avs_address_in == ADDR_CTRL)
				next_ctrl = avs_writedata_in[5:0];
			else if (avs_address_in == ADDR_BAUD)
				next_baud_div = avs_writedata_in[BAUD_W-1:0];
			else if (avs_address_in == ADDR_INT_STAT)
				int_clr = avs_writedata_in[INT_W-1:0];
			else if (avs_address_in == ADDR_INT_MASK)
				next_int_mask = avs_writedata_in[INT_W-1:0];
		end
		// Read data is prepared while waitrequest is high.
		if (avs_read_in && avs_waitrequest_out) begin
			next_readdata = 32'h0000_0000;
			if (avs_address_in == ADDR_CTRL)
				next_readdata[5:0] = ctrl;
			else if (avs_address_in == ADDR_BAUD)
				next_readdata[BAUD_W-1:0] = baud_div;
			else if (avs_address_in == ADDR_DATA)
				next_readdata[9:0] = rx_complete_flag ? head : 10'h000;
			else if (avs_address_in == ADDR_STATUS) begin
				next_readdata[STAT_RXC]              = rx_complete_flag;
				next_readdata[STAT_FE]               = rx_complete_flag &&
					head.frame_err;
				next_readdata[STAT_CNT+1:STAT_CNT]   = fifo_cnt;
				next_readdata[STAT_BUSY]             = state != ST_IDLE;
				next_readdata[STAT_OWNED]            =
					serial_input_pin_owned_out;
			end else if (avs_address_in == ADDR_INT_STAT)
				next_readdata[INT_W-1:0] = int_stat;
			else if (avs_address_in == ADDR_INT_MASK)
				next_readdata[INT_W-1:0] = int_mask;
		end
		// Flushing wins over everything; unread frames are lost.
		if (!ctrl.enable) begin
			next_fifo_cnt = 2'h0;
			next_rd_ptr   = 1'b0;
		end
		int_set[INT_RX]    = push_ok;
		int_set[INT_FE]    = push_ok && push_entry.frame_err;
		int_set[INT_OVR]   = push && !push_ok;
		int_set[INT_NOISE] = noise_evt;
		// A new event in the same cycle as its clear keeps the flag set.
		next_int_stat = (int_stat & ~int_clr) | int_set;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			ctrl                       <= CTRL_RESET;
			baud_div                   <= BAUD_W'(BAUD_RESET);
			int_stat                   <= '0;
			int_mask                   <= '0;
			rd_ptr                     <= 1'b0;
			fifo_cnt                   <= 2'h0;
			avs_waitrequest_out        <= 1'b1;
			avs_readdata_out           <= 32'h0000_0000;
			irq_out                    <= 1'b0;
			serial_input_pin_owned_out <= 1'b0;
		end else begin
			ctrl                       <= next_ctrl;
			baud_div                   <= next_baud_div;
			int_stat                   <= next_int_stat;
			int_mask                   <= next_int_mask;
			rd_ptr                     <= next_rd_ptr;
			fifo_cnt                   <= next_fifo_cnt;
			avs_waitrequest_out        <= next_waitreq;
			avs_readdata_out           <= next_readdata;
			irq_out                    <= |(int_stat & int_mask);
			serial_input_pin_owned_out <= ctrl.enable;
		end
	end

	// Buffer storage needs no reset; the count says what is valid.
	always_ff @(posedge sys_clk_in) begin
		if (mem_we)
			fifo_mem[mem_idx] <= push_entry;
	end

	property p_flush;
		!ctrl.enable |=> fifo_cnt == 2'h0;
	endproperty
	a_flush: assert property (p_flush)
		else $error("receive buffer not flushed on disable");

	property p_flag_clear;
		!ctrl.enable ##1 !ctrl.enable |-> !rx_complete_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("receive complete flag set while disabled");

	property p_release_pin;
		!ctrl.enable ##1 !ctrl.enable |-> !serial_input_pin_owned_out;
	endproperty
	a_release_pin: assert property (p_release_pin)
		else $error("pin still claimed while receiver disabled");

	property p_frame_error;
		push && push_entry.frame_err && fifo_cnt != FIFO_FULL
			|=> int_stat[INT_FE] &&
			fifo_cnt == $past(fifo_cnt) + 2'h1 - {1'b0, $past(pop)};
	endproperty
	a_frame_error: assert property (p_frame_error)
		else $error("zero stop bit did not raise frame error");

endmodule

// ---- tb/uart_async_receiver_recovery_tb.sv ----
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		mismatches++; \
		$display("[ERR] %s exp %h got %h", nm, ex, got); \
	end \
end
module uart_async_receiver_recovery_tb;
	import uarx_pkg::*;
	logic        sys_clk_in  = 1'b0;
	logic        resetn_in   = 1'b0;
	logic [7:0]  addr        = 8'h00;
	logic        rd          = 1'b0;
	logic        wr          = 1'b0;
	logic [31:0] wdata       = 32'h0;
	logic        wait_req;
	logic [31:0] rdata;
	logic        irq;
	logic        rx_line;
	logic        owned;
	int          mismatches  = 0;
	int          checks_done = 0;
	int          seed        = 48;
	int          bl          = 32;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] e_v;
	logic [31:0] m_v;
	logic [9:0]  dv[3];

	uarx_receiver u_dut (
		.sys_clk_in                 (sys_clk_in),
		.resetn_in                  (resetn_in),
		.avs_address_in             (addr),
		.avs_read_in                (rd),
		.avs_write_in               (wr),
		.avs_writedata_in           (wdata),
		.avs_waitrequest_out        (wait_req),
		.avs_readdata_out           (rdata),
		.irq_out                    (irq),
		.serial_input_pin_in        (rx_line),
		.serial_input_pin_owned_out (owned)
	);

	uarx_serial_tx u_tx (
		.clk_in   (sys_clk_in),
		.line_out (rx_line)
	);

	// Free-running 100 MHz clock.
	always #5 sys_clk_in = ~sys_clk_in;

	// Read data is judged against the oldest noted expectation.
	always @(posedge sys_clk_in) begin
		if (rd && wait_req === 1'b0 && exp_q.size() > 0) begin
			e_v = exp_q.pop_front();
			m_v = msk_q.pop_front();
			`CHK("readdata", e_v & m_v, rdata & m_v)
		end
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One bus cycle held until waitrequest is seen low, then an idle
	// edge so that the next request never lands in the same step.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] ex, input logic [31:0] m);
		int n;
		n = 0;
		addr  <= a;
		wdata <= d;
		rd    <= ~w;
		wr    <= w;
		if (!w) begin
			exp_q.push_back(ex);
			msk_q.push_back(m);
		end
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			$display("[ERR] waitrequest exp 0 got %b", wait_req);
		end
		@(posedge sys_clk_in);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex,
		input logic [31:0] m);
		bus(1'b0, a, 32'h0, ex, m);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask

	// An 8-bit frame followed by one idle bit period.
	task automatic frame(input logic [9:0] d, input logic sv);
		u_tx.send(d, 8, bl, sv, bl);
		repeat (bl) @(posedge sys_clk_in);
	endtask

	task automatic rd_byte(input logic [9:0] d, input logic fe);
		rd_chk(ADDR_DATA, {22'h0, fe, 1'b0, d[7:0]}, 32'hFFFFFFFF);
	endtask

	// The whole run should end well inside this span.
	initial begin
		repeat (60000) @(posedge sys_clk_in);
		mismatches++;
		test_done();
	end

	initial begin
		logic [9:0] d;
		logic [8:0] m9;
		int         nb;
		repeat (12) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		`CHK("owned", 1'b0, owned)
		rd_chk(ADDR_CTRL, 32'h0C, 32'hFFFFFFFF);
		rd_chk(ADDR_BAUD, 32'h67, 32'hFFFFFFFF);
		rd_chk(ADDR_INT_MASK, 32'h0, 32'hFFFFFFFF);
		rd_chk(ADDR_INT_STAT, 32'h0, 32'hFFFFFFFF);
		rd_chk(8'h3C, 32'h0, 32'hFFFFFFFF);
		// Divisor 1 gives a tick every two clocks, 32 clocks a bit.
		wr_reg(ADDR_BAUD, 32'h1);
		wr_reg(ADDR_INT_MASK, 32'h1);
		// Every character size with and without a parity bit.
		for (int c = 0; c < 5; c++) begin
			for (int p = 0; p < 2; p++) begin
				wr_reg(ADDR_CTRL, {26'h0, p[0], c[2:0], 2'b01});
				// The pin flag follows the enable one edge later.
				@(posedge sys_clk_in);
				`CHK("owned", 1'b1, owned)
				d  = 10'($random(seed));
				nb = 5 + c + p;
				m9 = DATA_MASK_ALL >> (4 - c);
				u_tx.send(d, nb, bl, 1'b1, bl);
				repeat (bl) @(posedge sys_clk_in);
				`CHK("irq", 1'b1, irq)
				rd_chk(ADDR_DATA, {23'h0, d[8:0] & m9}, 32'hFFFFFFFF);
				wr_reg(ADDR_INT_STAT, 32'h1);
				@(posedge sys_clk_in);
				`CHK("irq", 1'b0, irq)
			end
		end
		// A zero stop bit, with its interrupt masked off.
		wr_reg(ADDR_CTRL, 32'h0D);
		wr_reg(ADDR_INT_MASK, 32'h2);
		wr_reg(ADDR_INT_MASK, 32'h0);
		d = 10'($random(seed));
		frame(d, 1'b0);
		`CHK("irq", 1'b0, irq)
		rd_chk(ADDR_STATUS, 32'h27, 32'h2F);
		rd_chk(ADDR_INT_STAT, 32'h3, 32'h3);
		rd_byte(d, 1'b1);
		wr_reg(ADDR_INT_STAT, 32'hF);
		// Seven low ticks lose the vote, ten low ticks win it.
		u_tx.glitch(14);
		repeat (3 * bl) @(posedge sys_clk_in);
		rd_chk(ADDR_INT_STAT, 32'h8, 32'hF);
		rd_chk(ADDR_STATUS, 32'h20, 32'h2F);
		u_tx.glitch(20);
		repeat (11 * bl) @(posedge sys_clk_in);
		rd_byte(10'h0FF, 1'b0);
		wr_reg(ADDR_INT_STAT, 32'hF);
		// Double speed with divisor 0: eight clocks a bit.
		wr_reg(ADDR_BAUD, 32'h0);
		wr_reg(ADDR_CTRL, 32'h0F);
		bl = 8;
		d  = 10'($random(seed));
		frame(d, 1'b1);
		rd_byte(d, 1'b0);
		wr_reg(ADDR_BAUD, 32'h1);
		wr_reg(ADDR_CTRL, 32'h0D);
		bl = 32;
		// Shortened stop bit, the next start follows at once.
		dv[0] = 10'($random(seed));
		dv[1] = 10'($random(seed));
		u_tx.send(dv[0], 8, bl, 1'b1, 24);
		frame(dv[1], 1'b1);
		rd_byte(dv[0], 1'b0);
		rd_byte(dv[1], 1'b0);
		// Third frame overruns the two-entry buffer.
		for (int i = 0; i < 3; i++) begin
			dv[i] = 10'($random(seed));
			frame(dv[i], 1'b1);
		end
		rd_chk(ADDR_STATUS, 32'h29, 32'h2F);
		rd_chk(ADDR_INT_STAT, 32'h4, 32'h4);
		rd_byte(dv[0], 1'b0);
		rd_byte(dv[1], 1'b0);
		rd_chk(ADDR_STATUS, 32'h20, 32'h21);
		rd_chk(ADDR_DATA, 32'h0, 32'hFFFFFFFF);
		// Disable mid-frame with one entry still unread.
		frame(dv[2], 1'b1);
		fork
			u_tx.send(10'h155, 8, bl, 1'b1, bl);
			begin
				repeat (5 * bl) @(posedge sys_clk_in);
				wr_reg(ADDR_CTRL, 32'h0C);
				@(posedge sys_clk_in);
				`CHK("owned", 1'b0, owned)
				rd_chk(ADDR_STATUS, 32'h0, 32'h3F);
			end
		join
		wr_reg(ADDR_CTRL, 32'h0D);
		repeat (bl) @(posedge sys_clk_in);
		rd_chk(ADDR_STATUS, 32'h20, 32'h3F);
		d = 10'($random(seed));
		frame(d, 1'b1);
		rd_byte(d, 1'b0);
		test_done();
	end
endmodule

// ---- tb/uarx_serial_tx.sv ----
`timescale 1ns/100ps
// Remote transmitter: the line idles high and bits go out LSB first.
module uarx_serial_tx (
	input  wire logic clk_in,
	output logic      line_out
);
	initial line_out = 1'b1;

	// Start bit, nb bits of d, then a stop level sv held sl clocks.
	// The bit period bl is an exact multiple of the sample tick.
	task automatic send(input logic [9:0] d, input int nb, input int bl,
		input logic sv, input int sl);
		line_out <= 1'b0;
		repeat (bl) @(posedge clk_in);
		for (int i = 0; i < nb; i++) begin
			line_out <= d[i];
			repeat (bl) @(posedge clk_in);
		end
		line_out <= sv;
		repeat (sl) @(posedge clk_in);
		// A high stop level is already idle; leaving it alone lets a
		// back-to-back start drive the line only once in this step.
		if (!sv)
			line_out <= 1'b1;
	endtask

	// A low pulse of len clocks, short ones mimic a noise spike.
	task automatic glitch(input int len);
		line_out <= 1'b0;
		repeat (len) @(posedge clk_in);
		line_out <= 1'b1;
	endtask
endmodule
